// ==== hdl/eeprom_ctrl_pkg.sv ====
`default_nettype none
package eeprom_ctrl_pkg;
  typedef logic [7:0] byte_t;
  localparam byte_t OP_SET_LATCH = 8'h06;
  localparam byte_t OP_CLEAR_LATCH = 8'h04;
  localparam byte_t OP_STATUS_WRITE = 8'h01;
  localparam byte_t OP_STATUS_READ = 8'h05;
  localparam byte_t OP_PAGE_ERASE = 8'h42;
  localparam byte_t OP_SECTOR_ERASE = 8'hd8;
  localparam byte_t OP_CHIP_ERASE = 8'hc7;
  localparam byte_t OP_DEEP_SLEEP = 8'hb9;
  localparam byte_t OP_WAKE_SIG = 8'hab;
  localparam int BIT_HW_PROTECT = 7;
  localparam int BIT_BP_HIGH = 3;
  localparam int BIT_BP_LOW = 2;
  localparam int BIT_LATCH = 1;
  localparam int BIT_BUSY = 0;
  localparam logic [1:0] BP_RESET = 2'h0;
  localparam logic [5:0] OP_BITS = 6'h08;
  localparam logic [5:0] ADDR_END_BITS = 6'h18;
  localparam logic [5:0] DATA_END_BITS = 6'h10;
  localparam logic [15:0] QUARTER_BASE = 16'hc000;
  localparam logic [15:0] HALF_BASE = 16'h8000;
  localparam int CLK_HZ = 20000000;
  localparam int PAGE_ERASE_US = 5000;
  localparam int SECTOR_ERASE_US = 10000;
  localparam int CHIP_ERASE_US = 10000;
  localparam int STATUS_WRITE_US = 5000;
  localparam int WAKE_DELAY_US = 100;
  localparam int PAGE_ERASE_CYC = PAGE_ERASE_US * (CLK_HZ / 1000000);
  localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_US * (CLK_HZ / 1000000);
  localparam int CHIP_ERASE_CYC = CHIP_ERASE_US * (CLK_HZ / 1000000);
  localparam int STATUS_WRITE_CYC = STATUS_WRITE_US * (CLK_HZ / 1000000);
  localparam int WAKE_DELAY_CYC = WAKE_DELAY_US * (CLK_HZ / 1000000);
  localparam byte_t SIGNATURE = 8'h5a;
endpackage
`default_nettype wire

// ==== hdl/serial_frame_if.sv ====
`default_nettype none
interface serial_frame_if;
  logic sel;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic sdi;
  modport front (output sel, rise, fall, start, stop, sdi);
  modport core (input sel, rise, fall, start, stop, sdi);
endinterface
`default_nettype wire

// ==== hdl/serial_pin_sync.sv ====
`default_nettype none
// brings the host pins into the core clock and finds clock and select edges
module serial_pin_sync (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic sel_n_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  serial_frame_if.front frame
);
  logic [1:0] sel_n_q, sclk_q, sdi_q;
  logic sel_last_q, sclk_last_q;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sel_n_q <= 2'h3;
      sclk_q <= 2'h0;
      sdi_q <= 2'h0;
      sel_last_q <= 1'b0;
      sclk_last_q <= 1'b0;
    end else begin
      sel_n_q <= {sel_n_q[0], sel_n_i};
      sclk_q <= {sclk_q[0], sclk_i};
      sdi_q <= {sdi_q[0], sdi_i};
      sel_last_q <= ~sel_n_q[1];
      sclk_last_q <= sclk_q[1];
    end
  end
  assign frame.sel = ~sel_n_q[1];
  assign frame.sdi = sdi_q[1];
  assign frame.rise = frame.sel & sclk_q[1] & ~sclk_last_q;
  assign frame.fall = frame.sel & ~sclk_q[1] & sclk_last_q;
  assign frame.start = frame.sel & ~sel_last_q;
  assign frame.stop = ~frame.sel & sel_last_q;
endmodule
`default_nettype wire

// ==== hdl/eeprom_protect_ctrl.sv ====
`default_nettype none
module eeprom_protect_ctrl #(
  parameter int PAGE_BITS = 7,
  parameter int PAGE_ERASE_CYCLES = eeprom_ctrl_pkg::PAGE_ERASE_CYC,
  parameter int SECTOR_ERASE_CYCLES = eeprom_ctrl_pkg::SECTOR_ERASE_CYC,
  parameter int CHIP_ERASE_CYCLES = eeprom_ctrl_pkg::CHIP_ERASE_CYC,
  parameter int STATUS_WRITE_CYCLES = eeprom_ctrl_pkg::STATUS_WRITE_CYC,
  parameter int WAKE_DELAY_CYCLES = eeprom_ctrl_pkg::WAKE_DELAY_CYC
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic sel_n_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  input wire logic wp_n_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic [15:0] erase_base_o,
  output logic [15:0] erase_last_o,
  output logic erase_active_o,
  output logic asleep_o,
  output eeprom_ctrl_pkg::byte_t device_status_o
);
  import eeprom_ctrl_pkg::*;

  if (PAGE_BITS < 1 || PAGE_BITS > 14) begin
    $error("page width unsupported");
  end
  if (WAKE_DELAY_CYCLES < 1 || CHIP_ERASE_CYCLES < 1 || PAGE_ERASE_CYCLES < 1) begin
    $error("delay too short");
  end

  typedef enum logic [1:0] {IDLE, BUSY, SLEEP, WAKING} mode_t;

  serial_frame_if frame ();
  serial_pin_sync u_sync (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .sel_n_i(sel_n_i),
    .sclk_i(sclk_i),
    .sdi_i(sdi_i),
    .frame(frame)
  );

  function automatic logic addr_protected(input logic [1:0] bp, input logic [15:0] a);
    case (bp)
      2'h0: addr_protected = 1'b0;
      2'h1: addr_protected = a >= QUARTER_BASE;
      2'h2: addr_protected = a >= HALF_BASE;
      default: addr_protected = 1'b1;
    endcase
  endfunction

  mode_t mode_q;
  logic latch_q, hw_en_q;
  logic [1:0] bp_q, bp_new_q;
  logic hw_new_q, nv_pend_q;
  logic [5:0] cnt_q;
  byte_t op_q;
  logic [15:0] shift_q, addr_q;
  logic [31:0] timer_q;
  byte_t tx_q;
  logic [15:0] base_q, last_q;
  logic erase_q;
  logic [1:0] wp_sync_q;
  wire logic wp_n_i_s = wp_sync_q[1];

  // status image, bit 0 busy, bit 1 latch
  wire logic busy = (mode_q == BUSY);
  wire byte_t status_now = {hw_en_q, 3'h0, bp_q, latch_q, busy};
  wire byte_t rx_byte = {shift_q[6:0], frame.sdi};
  wire logic op_done = frame.rise && cnt_q == OP_BITS - 6'h1;
  wire logic awake = (mode_q != SLEEP);
  wire logic hw_prot = ~wp_n_i_s & hw_en_q;
  wire logic [15:0] full_addr = {shift_q[14:0], frame.sdi};
  wire logic [15:0] page_mask = 16'hffff << PAGE_BITS;
  wire logic at_op_end = frame.stop && cnt_q == OP_BITS;
  wire logic at_addr_end = frame.stop && cnt_q == ADDR_END_BITS;
  wire logic at_data_end = frame.stop && cnt_q == DATA_END_BITS;
  wire logic idle_ok = (mode_q == IDLE);
  wire logic do_set = idle_ok && at_op_end && op_q == OP_SET_LATCH;
  wire logic do_clear = idle_ok && at_op_end && op_q == OP_CLEAR_LATCH;
  wire logic do_page = idle_ok && latch_q && at_addr_end && op_q == OP_PAGE_ERASE
    && !addr_protected(bp_q, addr_q);
  wire logic do_sector = idle_ok && latch_q && at_addr_end && op_q == OP_SECTOR_ERASE
    && !addr_protected(bp_q, addr_q);
  wire logic do_chip = idle_ok && latch_q && at_op_end && op_q == OP_CHIP_ERASE
    && bp_q == 2'h0;
  wire logic do_sw = idle_ok && latch_q && at_data_end && op_q == OP_STATUS_WRITE
    && !hw_prot;
  wire logic do_sleep = idle_ok && at_op_end && op_q == OP_DEEP_SLEEP;
  wire logic do_wake = mode_q == SLEEP && frame.stop && cnt_q >= OP_BITS
    && op_q == OP_WAKE_SIG;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) wp_sync_q <= 2'h3;
    else wp_sync_q <= {wp_sync_q[0], wp_n_i};
  end

  // bit counter and shifter
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || frame.start) begin
      cnt_q <= 6'h0;
      shift_q <= 16'h0;
      op_q <= 8'h0;
      addr_q <= 16'h0;
    end else if (frame.rise) begin
      shift_q <= full_addr;
      if (cnt_q != 6'h3f) cnt_q <= cnt_q + 6'h1;
      if (op_done) op_q <= rx_byte;
      if (cnt_q == ADDR_END_BITS - 6'h1) addr_q <= full_addr;
    end
  end

  // status and latch, nonvolatile bits written only at end of update
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      latch_q <= 1'b0;
      hw_en_q <= 1'b0;
      bp_q <= BP_RESET;
      hw_new_q <= 1'b0;
      bp_new_q <= BP_RESET;
      nv_pend_q <= 1'b0;
    end else begin
      if (do_set) latch_q <= 1'b1;
      if (do_clear || do_page || do_sector || do_chip || do_sw) latch_q <= 1'b0;
      if (do_sw) begin
        hw_new_q <= shift_q[BIT_HW_PROTECT];
        bp_new_q <= shift_q[BIT_BP_HIGH:BIT_BP_LOW];
        nv_pend_q <= 1'b1;
      end
      if (busy && timer_q == 32'h1 && nv_pend_q) begin
        hw_en_q <= hw_new_q;
        bp_q <= bp_new_q;
        nv_pend_q <= 1'b0;
      end
    end
  end

  // mode and self-timed cycles
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      mode_q <= IDLE;
      timer_q <= 32'h0;
      erase_q <= 1'b0;
      base_q <= 16'h0;
      last_q <= 16'h0;
    end else begin
      case (mode_q)
        IDLE: begin
          if (do_page) begin
            mode_q <= BUSY;
            timer_q <= 32'(PAGE_ERASE_CYCLES);
            erase_q <= 1'b1;
            base_q <= addr_q & page_mask;
            last_q <= addr_q | ~page_mask;
          end else if (do_sector) begin
            mode_q <= BUSY;
            timer_q <= 32'(SECTOR_ERASE_CYCLES);
            erase_q <= 1'b1;
            base_q <= {addr_q[15:14], 14'h0};
            last_q <= {addr_q[15:14], 14'h3fff};
          end else if (do_chip) begin
            mode_q <= BUSY;
            timer_q <= 32'(CHIP_ERASE_CYCLES);
            erase_q <= 1'b1;
            base_q <= 16'h0;
            last_q <= 16'hffff;
          end else if (do_sw) begin
            mode_q <= BUSY;
            timer_q <= 32'(STATUS_WRITE_CYCLES);
          end else if (do_sleep) begin
            mode_q <= SLEEP;
          end
        end
        BUSY: begin
          if (timer_q <= 32'h1) begin
            mode_q <= IDLE;
            erase_q <= 1'b0;
          end else begin
            timer_q <= timer_q - 32'h1;
          end
        end
        SLEEP: begin
          if (do_wake) begin
            mode_q <= WAKING;
            timer_q <= 32'(WAKE_DELAY_CYCLES);
          end
        end
        default: begin
          if (timer_q <= 32'h1) mode_q <= IDLE;
          else timer_q <= timer_q - 32'h1;
        end
      endcase
    end
  end

  // serial out: status repeats, signature after dummy address
  wire logic sr_phase = op_q == OP_STATUS_READ && awake && cnt_q >= OP_BITS;
  wire logic sig_phase = op_q == OP_WAKE_SIG && cnt_q >= ADDR_END_BITS;
  wire logic byte_edge = cnt_q[2:0] == 3'h0;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tx_q <= 8'h0;
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
    end else if (!frame.sel) begin
      sdo_oe_o <= 1'b0;
    end else if (frame.fall && (sr_phase || sig_phase)) begin
      sdo_oe_o <= 1'b1;
      if (byte_edge) begin
        sdo_o <= sr_phase ? status_now[7] : SIGNATURE[7];
        tx_q <= sr_phase ? {status_now[6:0], 1'b0} : {SIGNATURE[6:0], 1'b0};
      end else begin
        sdo_o <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      erase_base_o <= 16'h0;
      erase_last_o <= 16'h0;
      erase_active_o <= 1'b0;
      asleep_o <= 1'b0;
      device_status_o <= 8'h0;
    end else begin
      erase_base_o <= base_q;
      erase_last_o <= last_q;
      erase_active_o <= erase_q;
      asleep_o <= (mode_q == SLEEP);
      device_status_o <= status_now;
    end
  end

  // erase entry: busy with the erase flag on the next two clocks
  sequence s_erase_begin;
    busy && erase_q ##1 busy && erase_q;
  endsequence
  // frame closed while idle at a count other than a bare opcode
  sequence s_cut_frame;
    idle_ok && frame.stop && cnt_q != OP_BITS;
  endsequence

  a_latch_needs_set: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $rose(latch_q) |-> $past(do_set)) else $error("latch set without command");
  a_latch_clear_wr: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (do_sw || do_chip) |=> !latch_q) else $error("latch not cleared");
  a_latch_erase_clr: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (do_page || do_sector) |=> !latch_q) else $error("latch kept after erase");
  a_busy_start: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (do_page || do_sector) |=> s_erase_begin) else $error("erase did not start");
  a_chip_protect: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $rose(erase_q) && base_q == 16'h0 && last_q == 16'hffff |-> $past(bp_q) == 2'h0)
    else $error("chip erase while protected");
  a_chip_exact: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    s_cut_frame ##0 (op_q == OP_CHIP_ERASE) |=> !erase_q) else $error("cut chip erase ran");
  a_erase_latch: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $rose(erase_q) |-> $past(latch_q)) else $error("erase without latch");
  a_bp_only_sw: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !$stable(bp_q) |-> $past(busy) && $past(nv_pend_q)) else $error("bp changed");
  a_sleep_exact: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    s_cut_frame ##0 (op_q == OP_DEEP_SLEEP) |=> mode_q == IDLE)
    else $error("cut sleep entered");
  a_sleep_hold: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (mode_q == SLEEP && !do_wake) |=> mode_q == SLEEP) else $error("woke early");
  a_wake_start: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    do_wake |=> mode_q == WAKING) else $error("wake not started");
  a_sector_range: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    do_sector |=> last_q - base_q == 16'h3fff) else $error("sector span wrong");
  a_page_span: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    do_page |=> last_q - base_q == ~page_mask) else $error("page span wrong");
  a_hw_block: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (hw_prot && at_data_end && op_q == OP_STATUS_WRITE && idle_ok) |=> idle_ok && !nv_pend_q)
    else $error("status write while locked");
  a_status_first_bit: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (frame.fall && sr_phase && byte_edge) |=> sdo_o == $past(status_now[7]))
    else $error("status bit wrong");
endmodule
`default_nettype wire

// ==== verif/spi_host_model.sv ====
`default_nettype none
// host side of the serial link, mode 0, clock parked low between frames
module spi_host_model (
  input wire logic core_clk_i,
  input wire logic sdo_i,
  input wire logic sdo_oe_i,
  output logic sel_n_o,
  output logic sclk_o,
  output logic sdi_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sel_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end
  // nbits from tx msb down; rx collects sdo at the end of each high phase
  task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
    rx = '0;
    @(posedge core_clk_i);
    sel_n_o <= 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      sdi_o <= tx[i];
      repeat (4) @(posedge core_clk_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      rx = {rx[30:0], sdo_oe_i ? sdo_i : 1'bx};
      sclk_o <= 1'b0;
    end
    repeat (4) @(posedge core_clk_i);
    sel_n_o <= 1'b1;
    sdi_o <= ~sdi_o;
    repeat (8) @(posedge core_clk_i);
  endtask
endmodule
`default_nettype wire

// ==== verif/spi_eeprom_protect_erase_ctrl_test.sv ====
`default_nettype none
module spi_eeprom_protect_erase_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import eeprom_ctrl_pkg::*;
  localparam int CYC = 400;
  logic core_clk_i;
  logic sys_rst_i;
  logic wp_n_i;
  logic sel_n, sclk, sdi, sdo, sdo_oe;
  logic [15:0] erase_base, erase_last;
  logic erase_active, asleep;
  byte_t status;
  logic [31:0] rx;
  int n_fail = 0;
  int n_checks = 0;
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  eeprom_protect_ctrl #(.PAGE_ERASE_CYCLES(CYC), .SECTOR_ERASE_CYCLES(CYC),
    .CHIP_ERASE_CYCLES(CYC), .STATUS_WRITE_CYCLES(CYC), .WAKE_DELAY_CYCLES(CYC)) dut_u (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .sel_n_i(sel_n), .sclk_i(sclk),
    .sdi_i(sdi), .wp_n_i(wp_n_i), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .erase_base_o(erase_base), .erase_last_o(erase_last), .erase_active_o(erase_active),
    .asleep_o(asleep), .device_status_o(status));
  spi_host_model host_u (.core_clk_i(core_clk_i), .sdo_i(sdo), .sdo_oe_i(sdo_oe),
    .sel_n_o(sel_n), .sclk_o(sclk), .sdi_o(sdi));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (n_fail == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cmd(input logic [31:0] tx, input int nbits);
    host_u.xfer(tx, nbits, rx);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 1000 && (status[0] !== 1'b0 || erase_active !== 1'b0); i++) begin
      @(posedge core_clk_i);
    end
    check(status[0] | erase_active, 1'b0);
  endtask
  task automatic wsr(input byte_t v);
    cmd(OP_SET_LATCH, 8);
    cmd({OP_STATUS_WRITE, v}, 16);
    wait_idle();
  endtask
  // latch, erase frame, then only when the erase should run, busy read once over the link and waited out on the status port
  task automatic erase(input logic [31:0] tx, input int nbits, input logic on,
    input logic [15:0] b, input logic [15:0] l);
    cmd(OP_SET_LATCH, 8);
    cmd(tx, nbits);
    check(erase_active, on);
    if (on) begin
      check(erase_base, b);
      check(erase_last, l);
      cmd({OP_STATUS_READ, 8'h00}, 16);
      check(rx[0], 1'b1);
      wait_idle();
      check(status[1:0], 2'b00);
    end
  endtask
  initial begin
    repeat (60000) @(posedge core_clk_i);
    n_fail++;
    final_report();
  end
  initial begin
    sys_rst_i = 1'b1;
    wp_n_i = 1'b1;
    repeat (2) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    check(status, 8'h00);
    check(asleep, 1'b0);
    cmd(OP_SET_LATCH, 7);
    check(status[1], 1'b0);
    cmd({OP_SET_LATCH, 1'b0}, 9);
    check(status[1], 1'b0);
    cmd(OP_SET_LATCH, 8);
    check(status, 8'h02);
    cmd({OP_STATUS_READ, 16'h0000}, 24);
    check(rx[15:0], 16'h0202);
    cmd(OP_CLEAR_LATCH, 8);
    check(status[1], 1'b0);
    cmd({OP_STATUS_WRITE, 8'h8c}, 16);
    wait_idle();
    check(status, 8'h00);
    cmd(OP_SET_LATCH, 8);
    cmd({OP_CHIP_ERASE, 1'b0}, 9);
    check(erase_active, 1'b0);
    erase(OP_CHIP_ERASE, 8, 1'b1, 16'h0000, 16'hffff);
    wsr(8'hf4);
    check(status, 8'h84);
    erase(OP_CHIP_ERASE, 8, 1'b0, 16'h0, 16'h0);
    erase({OP_PAGE_ERASE, 16'hc000}, 24, 1'b0, 16'h0, 16'h0);
    erase({OP_PAGE_ERASE, 16'hbfff}, 24, 1'b1, 16'hbf80, 16'hbfff);
    erase({OP_PAGE_ERASE, 8'h12}, 16, 1'b0, 16'h0, 16'h0);
    erase({OP_SECTOR_ERASE, 16'h8123}, 24, 1'b1, 16'h8000, 16'hbfff);
    erase({OP_SECTOR_ERASE, 16'hc001}, 24, 1'b0, 16'h0, 16'h0);
    wp_n_i <= 1'b0;
    wsr(8'h00);
    check(status[7:2], 6'h21);
    cmd(OP_CLEAR_LATCH, 8);
    check(status[1], 1'b0);
    cmd(OP_SET_LATCH, 8);
    check(status[1], 1'b1);
    erase({OP_PAGE_ERASE, 16'h0005}, 24, 1'b1, 16'h0000, 16'h007f);
    wp_n_i <= 1'b1;
    wsr(8'h08);
    check(status, 8'h08);
    erase({OP_SECTOR_ERASE, 16'h4000}, 24, 1'b1, 16'h4000, 16'h7fff);
    erase({OP_SECTOR_ERASE, 16'h8000}, 24, 1'b0, 16'h0, 16'h0);
    wsr(8'h0c);
    erase({OP_PAGE_ERASE, 16'h0000}, 24, 1'b0, 16'h0, 16'h0);
    wsr(8'h00);
    check(status, 8'h00);
    cmd({OP_DEEP_SLEEP, 1'b0}, 9);
    check(asleep, 1'b0);
    cmd(OP_DEEP_SLEEP, 8);
    check(asleep, 1'b1);
    cmd(OP_SET_LATCH, 8);
    check(status[1], 1'b0);
    cmd({OP_WAKE_SIG, 24'h000000}, 32);
    check(rx[7:0], SIGNATURE);
    repeat (CYC + 20) @(posedge core_clk_i);
    check(asleep, 1'b0);
    cmd(OP_SET_LATCH, 8);
    check(status[1], 1'b1);
    cmd(OP_DEEP_SLEEP, 8);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    check(asleep, 1'b0);
    check(status[1], 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
